// >>> core/srd_bank.v
// Reset-defaults register bank for status, diagnosis, interrupt and configuration registers.
//
// Contract
// - Power-on: source 0000, power flag 1; start-up/restart take sequencer source code, disallowed codes become 0000.
// - CAN wake flag: cleared at power-on, set on CAN wake start-up, else kept.
// - LIN wake flag: cleared at power-on, set on LIN wake start-up, else kept.
// - Edge wake flag: cleared at power-on, set on pin-wake start-up, else kept.
// - Wake level, development flags live; temperature warning 0 until first start-up or restart.
// - Enable status reads 0 unless emulation is on, then live CAN failure status.
// - Diagnosis fields hold power-on defaults, then show live state after start-up or restart.
// - Interrupt enables cleared at power-on only, kept on start-up and restart.
// - Interrupt flags cleared on power-on, start-up and restart.
// - Threshold, V3, current monitor, wake enable, wake sample loaded at power-on only.
// - Reset length short at power-on, kept at start-up, long on restart and fail-safe.
// - Limp enable 0 at power-on, 1 fail-safe, restart clears if control 1.
// - Partial networking 0 at power-on, fail-safe, and CAN-wake start-up; else kept.
// - V2 control automatic at power-on and fail-safe, kept otherwise.
// - Other physical layer fields loaded at power-on only, kept by later resets.
`timescale 1ns/1ns
`include "srd_map.vh"

module srd_bank #(
  parameter IRQ_W = 12
) (
  input  wire              mclk,
  input  wire              reset,
  input  wire [3:0]        reset_event,
  input  wire              wake_cause_can,
  input  wire              wake_cause_lin,
  input  wire              wake_cause_pin,
  input  wire [3:0]        restart_source,
  input  wire [3:0]        startup_source,
  input  wire              wake_level_pin,
  input  wire              sw_development_live,
  input  wire              temperature_warning_live,
  input  wire              ground_shift_live,
  input  wire [3:0]        can_failure_live,
  input  wire [1:0]        lin_failure_live,
  input  wire              v3_ok_live,
  input  wire              v2_ok_live,
  input  wire              v1_ok_live,
  input  wire [1:0]        can_mode_live,
  input  wire [IRQ_W-1:0]  irq_event,
  input  wire [3:0]        reg_addr,
  input  wire [15:0]       reg_wdata,
  input  wire              reg_write,
  input  wire              reg_read,
  output reg  [15:0]       reg_rdata,
  output reg               irq,
  output reg  [11:0]       sys_config,
  output reg  [11:0]       phy_config,
  output reg  [IRQ_W-1:0]  irq_enable,
  output reg  [IRQ_W-1:0]  irq_flag,
  output reg               enable_output_status
);

  // ==========================================================
  // Event decode
  wire ev_pon = reset_event[`SRD_EV_POWER_ON];
  wire ev_su  = reset_event[`SRD_EV_START_UP];
  wire ev_rs  = reset_event[`SRD_EV_RESTART];
  wire ev_fs  = reset_event[`SRD_EV_FAIL_SAFE];

  wire wr_sc  = reg_write && (reg_addr == `SRD_ADDR_SYS_CFG);
  wire wr_pl  = reg_write && (reg_addr == `SRD_ADDR_PHY_CFG);
  wire wr_ie  = reg_write && (reg_addr == `SRD_ADDR_IRQ_EN);
  wire wr_if  = reg_write && (reg_addr == `SRD_ADDR_IRQ_FLAG);
  wire wr_sp  = reg_write && (reg_addr == `SRD_ADDR_SPECIAL);
  wire wr_msk = reg_write && (reg_addr == `SRD_ADDR_EVT_MASK);
  wire rd_evs = reg_read  && (reg_addr == `SRD_ADDR_EVT_STAT);

  // ==========================================================
  // State
  reg [3:0]  reset_source_field;
  reg        power_on_flag;
  reg        can_wake_flag;
  reg        lin_wake_flag;
  reg        local_edge_wake_flag;
  reg        live_valid;
  reg        error_pin_emulation;
  reg [3:0]  evt_status;
  reg [3:0]  evt_mask;

  // The wake level pin passes three flops; a change counts when the last two agree.
  reg [2:0]  wake_sync;
  reg        wake_level_flag;

  // Restart may only report one of four codes; anything else falls back to 0000.
  function [3:0] srd_restart_code;
    input [3:0] code;
    begin
      if ((code == `SRD_RSS_RS_B) || (code == `SRD_RSS_RS_C) || (code == `SRD_RSS_RS_D)) begin
        srd_restart_code = code;
      end else begin
        srd_restart_code = `SRD_RSS_RS_A;
      end
    end
  endfunction

  always @(posedge mclk) begin
    if (reset) begin
      wake_sync       <= 3'h0;
      wake_level_flag <= 1'b0;
    end else begin
      wake_sync <= {wake_sync[1:0], wake_level_pin};
      if (wake_sync[2] == wake_sync[1]) begin
        wake_level_flag <= wake_sync[2];
      end
    end
  end

  // ==========================================================
  // System status
  always @(posedge mclk) begin
    if (reset) begin
      reset_source_field   <= `SRD_RSS_POWER_ON;
      power_on_flag        <= 1'b1;
      can_wake_flag        <= 1'b0;
      lin_wake_flag        <= 1'b0;
      local_edge_wake_flag <= 1'b0;
      live_valid           <= 1'b0;
    end else if (ev_pon) begin
      reset_source_field   <= `SRD_RSS_POWER_ON;
      power_on_flag        <= 1'b1;
      can_wake_flag        <= 1'b0;
      lin_wake_flag        <= 1'b0;
      local_edge_wake_flag <= 1'b0;
      live_valid           <= 1'b0;
    end else if (ev_su) begin
      // A start-up must never report code 1100; it is replaced by the power-on code.
      if (startup_source != `SRD_RSS_SU_BAD) begin
        reset_source_field <= startup_source;
      end else begin
        reset_source_field <= `SRD_RSS_POWER_ON;
      end
      if (wake_cause_can) begin
        can_wake_flag <= 1'b1;
      end
      if (wake_cause_lin) begin
        lin_wake_flag <= 1'b1;
      end
      if (wake_cause_pin) begin
        local_edge_wake_flag <= 1'b1;
      end
      live_valid <= 1'b1;
    end else if (ev_rs) begin
      reset_source_field <= srd_restart_code(restart_source);
      live_valid         <= 1'b1;
    end
  end

  // ==========================================================
  // Configuration registers
  always @(posedge mclk) begin
    if (reset) begin
      sys_config          <= `SRD_SC_RESET;
      phy_config          <= `SRD_PL_RESET;
      irq_enable          <= {IRQ_W{1'b0}};
      error_pin_emulation <= 1'b0;
    end else if (ev_pon) begin
      sys_config          <= `SRD_SC_RESET;
      phy_config          <= `SRD_PL_RESET;
      irq_enable          <= {IRQ_W{1'b0}};
      error_pin_emulation <= 1'b0;
    end else if (ev_fs) begin
      sys_config[`SRD_SC_RLC]  <= 1'b1;
      sys_config[`SRD_SC_LIMP_HOME_ENABLE] <= 1'b1;
      sys_config[`SRD_SC_ILC]  <= 1'b0;
      phy_config[`SRD_PL_V2C]  <= 1'b0;
      phy_config[`SRD_PL_CPN]  <= 1'b0;
    end else if (ev_rs) begin
      sys_config[`SRD_SC_RLC] <= 1'b1;
      if (sys_config[`SRD_SC_ILC]) begin
        sys_config[`SRD_SC_LIMP_HOME_ENABLE] <= 1'b0;
      end
    end else if (ev_su) begin
      if (wake_cause_can) begin
        phy_config[`SRD_PL_CPN] <= 1'b0;
      end
    end else begin
      if (wr_sc) begin
        sys_config <= reg_wdata[11:0];
      end
      if (wr_pl) begin
        phy_config <= reg_wdata[11:0];
      end
      if (wr_ie) begin
        irq_enable <= reg_wdata[IRQ_W-1:0];
      end
      if (wr_sp) begin
        error_pin_emulation <= reg_wdata[0];
      end
    end
  end

  // ==========================================================
  // Interrupt flags: new events win over a write-one clear.
  always @(posedge mclk) begin
    if (reset) begin
      irq_flag <= {IRQ_W{1'b0}};
    end else if (ev_pon || ev_su || ev_rs) begin
      irq_flag <= {IRQ_W{1'b0}};
    end else if (wr_if) begin
      irq_flag <= (irq_flag & ~reg_wdata[IRQ_W-1:0]) | (irq_event & irq_enable);
    end else begin
      irq_flag <= irq_flag | (irq_event & irq_enable);
    end
  end

  // ==========================================================
  // Sequencer event status, cleared by reading; a new event beats the clear.
  always @(posedge mclk) begin
    if (reset) begin
      evt_status <= 4'h0;
      evt_mask   <= 4'h0;
      irq        <= 1'b0;
    end else begin
      if (rd_evs) begin
        evt_status <= reset_event;
      end else begin
        evt_status <= evt_status | reset_event;
      end
      if (wr_msk) begin
        evt_mask <= reg_wdata[3:0];
      end
      irq <= |(evt_status & evt_mask) || |irq_flag;
    end
  end

  // ==========================================================
  // Enable status and readback
  always @(posedge mclk) begin
    if (reset) begin
      enable_output_status <= 1'b0;
    end else if (error_pin_emulation) begin
      enable_output_status <= (can_failure_live == `SRD_CAN_FAILURE_DIAG_OK);
    end else begin
      enable_output_status <= 1'b0;
    end
  end

  wire [3:0] diag_can_failure_diag = live_valid ? can_failure_live : `SRD_CAN_FAILURE_DIAG_OK;
  wire [1:0] diag_lin_failure_diag = live_valid ? lin_failure_live : `SRD_LIN_FAILURE_DIAG_OK;
  wire [1:0] diag_can_mode_diag = live_valid ? can_mode_live : `SRD_CAN_MODE_DIAG_OFFLINE;

  reg [15:0] next_rdata;

  always @* begin
    next_rdata = 16'h0000;
    case (reg_addr)
      `SRD_ADDR_STATUS: begin
        next_rdata = {4'h0, reset_source_field, can_wake_flag, lin_wake_flag,
                      local_edge_wake_flag, wake_level_flag,
                      temperature_warning_live & live_valid, sw_development_live,
                      enable_output_status, power_on_flag};
      end
      `SRD_ADDR_DIAG: begin
        next_rdata = {4'h0, live_valid ? ground_shift_live : 1'b0, diag_can_failure_diag, diag_lin_failure_diag,
                      live_valid ? v3_ok_live : 1'b1, live_valid ? v2_ok_live : 1'b1,
                      live_valid ? v1_ok_live : 1'b0, diag_can_mode_diag};
      end
      `SRD_ADDR_IRQ_EN:   next_rdata = {{(16-IRQ_W){1'b0}}, irq_enable};
      `SRD_ADDR_IRQ_FLAG: next_rdata = {{(16-IRQ_W){1'b0}}, irq_flag};
      `SRD_ADDR_SYS_CFG:  next_rdata = {4'h0, sys_config};
      `SRD_ADDR_PHY_CFG:  next_rdata = {4'h0, phy_config};
      `SRD_ADDR_SPECIAL:  next_rdata = {15'h0000, error_pin_emulation};
      `SRD_ADDR_EVT_STAT: next_rdata = {12'h000, evt_status};
      `SRD_ADDR_EVT_MASK: next_rdata = {12'h000, evt_mask};
      default:            next_rdata = 16'h0000;
    endcase
  end

  always @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

// >>> core/srd_map.vh
// Register offsets, field defaults and event codes of the reset-defaults register bank.
`ifndef SRD_MAP_VH
`define SRD_MAP_VH

// ==========================================================
// Register offsets
`define SRD_ADDR_STATUS    4'h0
`define SRD_ADDR_DIAG      4'h1
`define SRD_ADDR_IRQ_EN    4'h2
`define SRD_ADDR_IRQ_FLAG  4'h3
`define SRD_ADDR_SYS_CFG   4'h4
`define SRD_ADDR_PHY_CFG   4'h5
`define SRD_ADDR_SPECIAL   4'h6
`define SRD_ADDR_EVT_STAT  4'h7
`define SRD_ADDR_EVT_MASK  4'h8

// ==========================================================
// Event input bits (one-hot)
`define SRD_EV_POWER_ON    0
`define SRD_EV_START_UP    1
`define SRD_EV_RESTART     2
`define SRD_EV_FAIL_SAFE   3

// ==========================================================
// Field values
`define SRD_RSS_POWER_ON   4'h0
`define SRD_RSS_SU_BAD     4'hC
`define SRD_RSS_RS_A       4'h0
`define SRD_RSS_RS_B       4'h2
`define SRD_RSS_RS_C       4'hC
`define SRD_RSS_RS_D       4'hE
`define SRD_CAN_FAILURE_DIAG_OK       4'h0
`define SRD_LIN_FAILURE_DIAG_OK       2'h0
`define SRD_CAN_MODE_DIAG_OFFLINE  2'h0
`define SRD_V3C_OFF        2'h0

// ==========================================================
// System configuration bit positions
`define SRD_SC_GSTH        0
`define SRD_SC_RLC         1
`define SRD_SC_V3C_LO      2
`define SRD_SC_V1CM        4
`define SRD_SC_WEN         5
`define SRD_SC_WSC         6
`define SRD_SC_LIMP_HOME_ENABLE        7
`define SRD_SC_ILC         8

// Physical layer bit positions.
`define SRD_PL_V2C         0
`define SRD_PL_CPN         1
`define SRD_PL_COT         2
`define SRD_PL_CTC         3
`define SRD_PL_CRC         4
`define SRD_PL_CMC         5
`define SRD_PL_LMC         6
`define SRD_PL_LSC         7
`define SRD_PL_LDC         8
`define SRD_PL_LIN_WAKE_ENABLE        9
`define SRD_PL_LTC         10

// Reset values of the writable configuration registers.
`define SRD_SC_RESET       12'h020
`define SRD_PL_RESET       12'h204
`define SRD_ZERO12         12'h000

`endif

// >>> verif/srd_bank_checker.sv
// Port assertions for the reset-defaults register bank.
`timescale 1ns/1ns
module srd_bank_checker #(
  parameter IRQ_W = 12
) (
  input wire             mclk,
  input wire             reset,
  input wire [3:0]       reset_event,
  input wire             wake_cause_can,
  input wire [3:0]       reg_addr,
  input wire [15:0]      reg_wdata,
  input wire             reg_write,
  input wire             irq,
  input wire [11:0]      sys_config,
  input wire [11:0]      phy_config,
  input wire [IRQ_W-1:0] irq_enable,
  input wire [IRQ_W-1:0] irq_flag,
  input wire             enable_output_status
);
  // ==========================================================
  // Emulation bit shadow
  // Cleared by reset only; a stale one here only skips a check, it never fires falsely.
  logic emul_q;
  always @(posedge mclk) begin
    if (reset)
      emul_q <= 1'b0;
    else if (reg_write && reg_addr == 4'h6 && reset_event == 4'h0)
      emul_q <= reg_wdata[0];
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // ==========================================================
  // Assertions
  AST_POWER_ON: assert property (reset_event == 4'h1 |=> sys_config == 12'h020
    && phy_config == 12'h204 && irq_enable == '0 && irq_flag == '0) else $error("power-on load");
  AST_START_UP_KEEP: assert property (reset_event == 4'h2 |=>
    sys_config[6:0] == $past(sys_config[6:0]) && irq_enable == $past(irq_enable)
    && phy_config[11:2] == $past(phy_config[11:2])) else $error("start-up lost a field");
  AST_START_UP_CAN: assert property (reset_event == 4'h2 && wake_cause_can |=> !phy_config[1])
    else $error("partial networking kept");
  AST_FLAGS_CLEAR: assert property (reset_event[2:0] != 3'h0 |=> irq_flag == '0)
    else $error("flags not cleared");
  AST_RESTART_LONG: assert property (reset_event == 4'h4 |=> sys_config[1])
    else $error("restart length short");
  AST_RESTART_LIMP: assert property (reset_event == 4'h4 && sys_config[8] |=> !sys_config[7])
    else $error("limp enable kept");
  AST_RESTART_KEEP: assert property (reset_event == 4'h4 && !sys_config[8] |=>
    sys_config[7] == $past(sys_config[7]) && phy_config == $past(phy_config))
    else $error("restart changed a kept field");
  AST_FAIL_SAFE: assert property (reset_event == 4'h8 |=> sys_config[1] && sys_config[7]
    && !sys_config[8] && phy_config[1:0] == 2'h0) else $error("fail-safe load");
  AST_ENS_LOW: assert property (!emul_q && !$past(emul_q) |-> !enable_output_status)
    else $error("enable status high");
  AST_IRQ_LEVEL: assert property (irq_flag != '0 |=> irq) else $error("irq missing");

  C_FAIL_SAFE: cover property (reset_event == 4'h8);
  C_RESTART_LIMP: cover property (reset_event == 4'h4 && sys_config[8]);
  C_CAN_WAKE: cover property (reset_event == 4'h2 && wake_cause_can);
endmodule

bind srd_bank srd_bank_checker #(.IRQ_W(IRQ_W)) srd_bank_checker_i (.*);

// >>> verif/srd_mcu_model.sv
// Microcontroller model that reads and writes the bank over its register port.
`timescale 1ns/1ns
module srd_mcu_model (
  input  wire         mclk,
  input  wire  [15:0] reg_rdata,
  output logic [3:0]  reg_addr,
  output logic [15:0] reg_wdata,
  output logic        reg_write,
  output logic        reg_read
);
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end

  // Released data is inverted so a bank that samples late cannot see a stale match.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

// >>> verif/tb_sbc_register_reset_defaults.sv
// Self-checking testbench for the reset-defaults register bank.
`timescale 1ns/1ns
module tb_sbc_register_reset_defaults;
  logic        mclk, reset, wake_cause_can, wake_cause_lin, wake_cause_pin, wake_level_pin;
  logic        sw_development_live, temperature_warning_live, ground_shift_live, irq;
  logic        v3_ok_live, v2_ok_live, v1_ok_live, reg_write, reg_read, enable_output_status;
  logic [1:0]  lin_failure_live, can_mode_live;
  logic [3:0]  reset_event, restart_source, startup_source, can_failure_live, reg_addr;
  logic [11:0] irq_event, sys_config, phy_config, irq_enable, irq_flag;
  logic [15:0] reg_wdata, reg_rdata, rd_v;
  int          fail_count, n_checks;

  srd_bank #(.IRQ_W(12)) srd_bank_i (.*);
  srd_mcu_model srd_mcu_model_i (.*);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (fail_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic ev(input logic [3:0] e);
    @(posedge mclk);
    reset_event <= e;
    @(posedge mclk);
    reset_event <= 4'h0;
    #1;
  endtask

  task automatic pulse(input logic [11:0] p);
    @(posedge mclk);
    irq_event <= p;
    @(posedge mclk);
    irq_event <= 12'h000;
    @(posedge mclk);
    #1;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_defaults(input logic [15:0] st);
    chk({4'h0, sys_config}, 16'h0020);
    chk({4'h0, phy_config}, 16'h0204);
    chk({4'h0, irq_enable}, 16'h0000);
    srd_mcu_model_i.rd(4'h0, rd_v);
    chk(rd_v, st);
    srd_mcu_model_i.rd(4'h1, rd_v);
    chk(rd_v, 16'h0018);
  endtask

  task automatic t_start_up();
    srd_mcu_model_i.wr(4'h5, 16'h0206);
    srd_mcu_model_i.wr(4'h2, 16'h0001);
    pulse(12'h003);
    chk({4'h0, irq_flag}, 16'h0001);
    chk(16'(irq), 16'h0001);
    startup_source <= 4'h3;
    wake_cause_can <= 1'b1;
    wake_cause_pin <= 1'b1;
    ev(4'h2);
    chk({4'h0, phy_config}, 16'h0204);
    chk({4'h0, irq_flag}, 16'h0000);
    chk({4'h0, irq_enable}, 16'h0001);
    srd_mcu_model_i.rd(4'h0, rd_v);
    chk(rd_v, 16'h03AD);
    srd_mcu_model_i.rd(4'h1, rd_v);
    chk(rd_v, 16'h0ACD);
    startup_source <= 4'hC;
    wake_cause_can <= 1'b0;
    wake_cause_pin <= 1'b0;
    wake_cause_lin <= 1'b1;
    ev(4'h2);
    wake_cause_lin <= 1'b0;
    srd_mcu_model_i.rd(4'h0, rd_v);
    chk(rd_v, 16'h00ED);
  endtask

  task automatic t_restart_fail_safe();
    srd_mcu_model_i.wr(4'h4, 16'h01A5);
    restart_source <= 4'hE;
    ev(4'h4);
    chk({4'h0, sys_config}, 16'h0127);
    srd_mcu_model_i.rd(4'h0, rd_v);
    chk(rd_v, 16'h0EED);
    restart_source <= 4'h5;
    srd_mcu_model_i.wr(4'h5, 16'h0207);
    ev(4'h4);
    chk({4'h0, phy_config}, 16'h0207);
    srd_mcu_model_i.rd(4'h0, rd_v);
    chk(rd_v, 16'h00ED);
    ev(4'h8);
    chk({4'h0, phy_config}, 16'h0204);
    chk({4'h0, sys_config}, 16'h00A7);
    ev(4'h4);
    chk({4'h0, sys_config}, 16'h00A7);
  endtask

  task automatic t_irq_emulation();
    pulse(12'h002);
    chk({4'h0, irq_flag}, 16'h0000);
    chk(16'(irq), 16'h0000);
    pulse(12'h001);
    chk(16'(irq), 16'h0001);
    srd_mcu_model_i.wr(4'h3, 16'h0001);
    @(posedge mclk);
    #1;
    chk({4'h0, irq_flag}, 16'h0000);
    chk(16'(irq), 16'h0000);
    srd_mcu_model_i.rd(4'hF, rd_v);
    chk(rd_v, 16'h0000);
    srd_mcu_model_i.wr(4'h6, 16'h0001);
    can_failure_live <= 4'h0;
    repeat (2) @(posedge mclk);
    #1;
    chk(16'(enable_output_status), 16'h0001);
    can_failure_live <= 4'h5;
    repeat (2) @(posedge mclk);
    #1;
    chk(16'(enable_output_status), 16'h0000);
    srd_mcu_model_i.wr(4'h6, 16'h0000);
    wake_level_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    srd_mcu_model_i.rd(4'h0, rd_v);
    chk(rd_v, 16'h00FD);
    wake_level_pin <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
  endtask

  initial begin
    reset = 1'b1;
    reset_event = 4'h0;
    {wake_cause_can, wake_cause_lin, wake_cause_pin, wake_level_pin} = 4'h0;
    {restart_source, startup_source, irq_event} = 20'h00000;
    {sw_development_live, temperature_warning_live, ground_shift_live} = 3'h7;
    {v3_ok_live, v2_ok_live, v1_ok_live} = 3'h3;
    can_failure_live = 4'h5;
    lin_failure_live = 2'h2;
    can_mode_live = 2'h1;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    #1;
    t_defaults(16'h0005);
    t_start_up();
    t_restart_fail_safe();
    t_irq_emulation();
    ev(4'h1);
    t_defaults(16'h0005);
    final_report();
  end

  initial begin
    #100000;
    fail_count++;
    final_report();
  end
endmodule
